// ==== core/slc_consts.svh ====
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH

// ****************************************************************
// Chain geometry
// ****************************************************************
`define SLC_NUM_LEDS        10
`define SLC_BITS_PER_LED    24
`define SLC_FRAME_BITS      240

// ****************************************************************
// Timing, figures in nanoseconds
// ****************************************************************
`define SLC_CLK_PERIOD_NS   25
`define SLC_BIT_PERIOD_NS   1250
`define SLC_ONE_HIGH_NS     800
`define SLC_ONE_LOW_NS      450
`define SLC_ZERO_HIGH_NS    400
`define SLC_ZERO_LOW_NS     850
`define SLC_RESET_LOW_NS    50000

// Least time in whole clock cycles, rounded up
`define SLC_CYC_MIN(ns) (((ns) + `SLC_CLK_PERIOD_NS - 1) / `SLC_CLK_PERIOD_NS)

// ****************************************************************
// Reset values
// ****************************************************************
`define SLC_CS_IDLE         1'b1
`define SLC_LINE_IDLE       1'b0

`endif

// ==== core/slc_led_drv.sv ====
`timescale 1ns/10ps
`include "slc_consts.svh"

// Notes on behaviour
// - While select is low, each rising serial clock edge shifts one data bit in.
// - The colour register holds 240 bits: ten LEDs, three 8-bit channels.
// - Output pulses are generated from the stored bits, one pulse per bit.
// - Each encoded bit lasts 1.25 us whether it is a one or a zero.
// - A one is 800 ns high then 450 ns low.
// - A zero is 400 ns high then 850 ns low.
// - Output goes in 24-bit groups, later groups for LEDs further along.
// - After the last group the line stays low at least 50 us.
module slc_led_drv
#(
    parameter int NUM_LEDS     = `SLC_NUM_LEDS,
    parameter int BITS_PER_LED = `SLC_BITS_PER_LED
)
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              spi_sclk,
    input  wire slc_pkg::slc_spi_t spi_in,
    output logic                   led_serial_out,
    output logic                   tx_busy
);
    import slc_pkg::*;

    // ************************************************************
    // Sizes and cycle counts
    // ************************************************************
    localparam int FRAME_BITS = NUM_LEDS * BITS_PER_LED;
    localparam int CNT_W      = 12;
    localparam int BIT_W      = $clog2(BITS_PER_LED);
    localparam int LED_W      = $clog2(NUM_LEDS);

    localparam logic [CNT_W-1:0] ONE_HIGH_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_ONE_HIGH_NS));
    localparam logic [CNT_W-1:0] ONE_LOW_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_ONE_LOW_NS));
    localparam logic [CNT_W-1:0] ZERO_HIGH_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_ZERO_HIGH_NS));
    localparam logic [CNT_W-1:0] ZERO_LOW_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_ZERO_LOW_NS));
    localparam logic [CNT_W-1:0] RESET_LOW_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_RESET_LOW_NS));
    localparam logic [CNT_W-1:0] BIT_CYC =
        CNT_W'(`SLC_CYC_MIN(`SLC_BIT_PERIOD_NS));

    localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(BITS_PER_LED - 1);
    localparam logic [LED_W-1:0] LAST_LED = LED_W'(NUM_LEDS - 1);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [FRAME_BITS-1:0] rx_frame;
    logic                  cs_meta_q;
    logic                  cs_sync_q;
    logic                  cs_prev_q;
    logic                  cs_rise;
    logic                  pending_q;
    logic                  pending_d;
    logic                  load;
    slc_state_t            state_q;
    slc_state_t            state_d;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      cnt_d;
    logic [BIT_W-1:0]      bit_q;
    logic [BIT_W-1:0]      bit_d;
    logic [LED_W-1:0]      led_q;
    logic [LED_W-1:0]      led_d;
    logic [FRAME_BITS-1:0] shift_q;
    logic [FRAME_BITS-1:0] shift_d;
    logic                  out_q;
    logic                  busy_q;

    // ************************************************************
    // Phase lengths per data bit
    // ************************************************************
    function automatic logic [CNT_W-1:0] high_len(input logic b);
        high_len = b ? ONE_HIGH_CYC : ZERO_HIGH_CYC;
    endfunction

    function automatic logic [CNT_W-1:0] low_len(input logic b);
        low_len = b ? ONE_LOW_CYC : ZERO_LOW_CYC;
    endfunction

    // ************************************************************
    // Serial receiver on the serial clock
    // ************************************************************
    slc_spi_rx
    #(
        .FRAME_BITS (FRAME_BITS)
    )
    u_rx
    (
        .spi_sclk   (spi_sclk),
        .resetn     (resetn),
        .spi_in     (spi_in),
        .rx_frame   (rx_frame)
    );

    // ************************************************************
    // Select synchroniser and rising edge
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_meta_q <= `SLC_CS_IDLE;
            cs_sync_q <= `SLC_CS_IDLE;
            cs_prev_q <= `SLC_CS_IDLE;
        end
        else
        begin
            cs_meta_q <= spi_in.cs_n;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    assign cs_rise = cs_sync_q & ~cs_prev_q;

    // ************************************************************
    // Frame request
    // ************************************************************
    // Received frame may only be copied while select is high and the
    // serial clock is idle, so the word is stable across the crossing
    assign load = (state_q == SLC_ST_IDLE) & pending_q & cs_sync_q;

    // A new rise in the cycle of the copy still counts
    assign pending_d = cs_rise | (pending_q & ~load);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_q <= 1'b0;
        end
        else
        begin
            pending_q <= pending_d;
        end
    end

    // ************************************************************
    // Encoder next state
    // ************************************************************
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        bit_d   = bit_q;
        led_d   = led_q;
        shift_d = shift_q;
        case (state_q)
            SLC_ST_IDLE:
            begin
                if (load)
                begin
                    shift_d = rx_frame;
                    bit_d   = '0;
                    led_d   = '0;
                    state_d = SLC_ST_HIGH;
                    cnt_d   = high_len(rx_frame[FRAME_BITS-1]) - 1'b1;
                end
            end
            SLC_ST_HIGH:
            begin
                if (cnt_q == '0)
                begin
                    state_d = SLC_ST_LOW;
                    cnt_d   = low_len(shift_q[FRAME_BITS-1]) - 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SLC_ST_LOW:
            begin
                if (cnt_q == '0)
                begin
                    shift_d = {shift_q[FRAME_BITS-2:0], 1'b0};
                    if (bit_q == LAST_BIT)
                    begin
                        bit_d = '0;
                        if (led_q == LAST_LED)
                        begin
                            state_d = SLC_ST_LATCH;
                            cnt_d   = RESET_LOW_CYC - 1'b1;
                        end
                        else
                        begin
                            led_d   = led_q + 1'b1;
                            state_d = SLC_ST_HIGH;
                            cnt_d   = high_len(shift_q[FRAME_BITS-2]) - 1'b1;
                        end
                    end
                    else
                    begin
                        bit_d   = bit_q + 1'b1;
                        state_d = SLC_ST_HIGH;
                        cnt_d   = high_len(shift_q[FRAME_BITS-2]) - 1'b1;
                    end
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SLC_ST_LATCH:
            begin
                if (cnt_q == '0)
                begin
                    state_d = SLC_ST_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default:
            begin
                state_d = SLC_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    // ************************************************************
    // Encoder state
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= SLC_ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Phase counter
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // Position in the chain
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_q <= '0;
            led_q <= '0;
        end
        else
        begin
            bit_q <= bit_d;
            led_q <= led_d;
        end
    end

    // ************************************************************
    // Transmit copy of the colour data
    // ************************************************************
    // Own copy so that a new frame can be received while sending
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_q <= '0;
        end
        else
        begin
            shift_q <= shift_d;
        end
    end

    // ************************************************************
    // Line and busy outputs
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_q  <= `SLC_LINE_IDLE;
            busy_q <= 1'b0;
        end
        else
        begin
            out_q  <= (state_d == SLC_ST_HIGH);
            busy_q <= (state_d != SLC_ST_IDLE);
        end
    end

    assign led_serial_out = out_q;
    assign tx_busy        = busy_q;

    // Sum of phases of a one is checked against one bit period
    initial
    begin
        if ((ONE_HIGH_CYC + ONE_LOW_CYC) != BIT_CYC)
        begin
            $error("one bit period mismatch");
        end
    end

endmodule

// ==== core/slc_pkg.sv ====
package slc_pkg;

    // ************************************************************
    // Serial port pins sampled on the serial clock
    // ************************************************************
    typedef struct packed {
        logic cs_n;
        logic mosi;
    } slc_spi_t;

    // ************************************************************
    // Line encoder states
    // ************************************************************
    typedef enum logic [2:0] {
        SLC_ST_IDLE  = 3'b000,
        SLC_ST_HIGH  = 3'b001,
        SLC_ST_LOW   = 3'b010,
        SLC_ST_LATCH = 3'b011
    } slc_state_t;

endpackage

// ==== core/slc_spi_rx.sv ====
`timescale 1ns/10ps
`include "slc_consts.svh"

module slc_spi_rx
#(
    parameter int FRAME_BITS = `SLC_FRAME_BITS
)
(
    input  wire logic                  spi_sclk,
    input  wire logic                  resetn,
    input  wire slc_pkg::slc_spi_t     spi_in,
    output logic [FRAME_BITS-1:0]      rx_frame
);
    import slc_pkg::*;

    logic [FRAME_BITS-1:0] shift_q;

    // ************************************************************
    // Shift in on the serial clock while selected
    // ************************************************************
    // First bit received ends up at the top after a full frame
    always_ff @(posedge spi_sclk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_q <= '0;
        end
        else if (!spi_in.cs_n)
        begin
            shift_q <= {shift_q[FRAME_BITS-2:0], spi_in.mosi};
        end
    end

    // Stable while select is high, since the clock is then idle
    assign rx_frame = shift_q;

endmodule

// ==== dv/slc_led_drv_props.sv ====
`timescale 1ns/10ps

module slc_led_drv_props
#(
    parameter int NUM_LEDS     = 10,
    parameter int BITS_PER_LED = 24
)
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              spi_sclk,
    input wire slc_pkg::slc_spi_t spi_in,
    input wire logic              led_serial_out,
    input wire logic              tx_busy
);
    import slc_pkg::*;

    // ********************
    // Pulse width and bit counters
    // ********************
    logic [11:0] hi_q;
    logic [11:0] lo_q;
    logic [11:0] hi_last_q;
    logic [8:0]  bits_q;

    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn) hi_q <= 12'h000;
        else hi_q <= led_serial_out ? hi_q + 12'h001 : 12'h000;

    // Starts saturated so the first frame sees a long idle gap
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn) lo_q <= 12'hfff;
        else if (led_serial_out) lo_q <= 12'h000;
        else if (lo_q != 12'hfff) lo_q <= lo_q + 12'h001;

    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn) hi_last_q <= 12'h000;
        else if (!led_serial_out && hi_q != 12'h000) hi_last_q <= hi_q;

    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn) bits_q <= 9'h000;
        else if (!tx_busy) bits_q <= 9'h000;
        else if ($rose(led_serial_out)) bits_q <= bits_q + 9'h001;

    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_sel_rise;
        !tx_busy ##1 $rose(spi_in.cs_n);
    endsequence

    a_start_latency: assert property (
        s_sel_rise |-> ##[2:6] led_serial_out)
        else $error("frame did not start after select rise");
    // Copy is gated by the synchronised select seen three samples back
    a_start_sel_high: assert property (
        $rose(tx_busy) |-> $past(spi_in.cs_n, 3))
        else $error("frame started while select low");
    a_high_width: assert property (
        $fell(led_serial_out) |-> hi_q == 12'd16 || hi_q == 12'd32)
        else $error("bad high phase width");
    a_one_shape: assert property (
        $rose(led_serial_out) && lo_q < 12'd100 && hi_last_q == 12'd32
        |-> lo_q == 12'd18)
        else $error("bad one bit low phase");
    a_zero_shape: assert property (
        $rose(led_serial_out) && lo_q < 12'd100 && hi_last_q == 12'd16
        |-> lo_q == 12'd34)
        else $error("bad zero bit low phase");
    a_frame_gap: assert property (
        $rose(led_serial_out) && lo_q >= 12'd100 |-> lo_q >= 12'd2000)
        else $error("gap between frames too short");
    a_busy_tail: assert property (
        $fell(tx_busy) |-> !led_serial_out && lo_q >= 12'd2018)
        else $error("busy ended before reset gap");
    a_bit_count: assert property (
        $fell(tx_busy) |-> bits_q == NUM_LEDS * BITS_PER_LED)
        else $error("wrong number of bits in frame");
    a_idle_low: assert property (!tx_busy |-> !led_serial_out)
        else $error("line high outside a frame");
endmodule

bind slc_led_drv slc_led_drv_props #(
    .NUM_LEDS     (NUM_LEDS),
    .BITS_PER_LED (BITS_PER_LED)
) u_props (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .spi_sclk       (spi_sclk),
    .spi_in         (spi_in),
    .led_serial_out (led_serial_out),
    .tx_busy        (tx_busy)
);

// ==== dv/slc_led_drv_tb_top.sv ====
`timescale 1ns/10ps

module slc_led_drv_tb_top;
    import slc_pkg::*;

    logic         core_clk;
    logic         resetn;
    logic         spi_sclk;
    logic         led_serial_out;
    logic         tx_busy;
    slc_spi_t     spi_in;
    int           err_count;
    int           total_checks;
    logic [239:0] pat_a;

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    slc_led_drv dut_u (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .spi_sclk       (spi_sclk),
        .spi_in         (spi_in),
        .led_serial_out (led_serial_out),
        .tx_busy        (tx_busy)
    );

    slc_spi_master u_master (
        .spi_sclk (spi_sclk),
        .spi_in   (spi_in)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask

    // ********************
    // Line decoder
    // ********************
    task automatic decode(input logic [239:0] f);
        int h;
        int l;
        int w;
        w = 0;
        while (led_serial_out !== 1'b1 && w < 400)
        begin
            @(negedge core_clk);
            w++;
        end
        chk(32'(tx_busy), 32'h1);
        for (int i = 239; i >= 0; i--)
        begin
            h = 0;
            l = 0;
            while (led_serial_out === 1'b1 && h < 100)
            begin
                @(negedge core_clk);
                h++;
            end
            while (led_serial_out !== 1'b1 && tx_busy === 1'b1 && l < 3000)
            begin
                @(negedge core_clk);
                l++;
            end
            chk(h, f[i] ? 32 : 16);
            if (i > 0) chk(h + l, 50);
        end
        chk(32'(l >= (f[0] ? 18 : 34) + 2000), 32'h1);
        chk(32'({led_serial_out, tx_busy}), 32'h0);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        chk(32'({led_serial_out, tx_busy}), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_full;
        pat_a = {24'h800001, {9{24'h5ac30f}}};
        u_master.send(pat_a, 240);
        decode(pat_a);
        $display("test full frame done");
    endtask

    // Short transfer leaves older bits at the front
    task automatic t_partial;
        u_master.send({216'h0, 24'h0ff00f}, 24);
        decode({pat_a[215:0], 24'h0ff00f});
        $display("test partial frame done");
    endtask

    // Second frame arrives while the first is on the line
    task automatic t_overlap;
        fork
            begin
                decode(~pat_a);
                decode(pat_a);
            end
            begin
                u_master.send(~pat_a, 240);
                repeat (500) @(negedge core_clk);
                u_master.send(pat_a, 240);
            end
        join
        $display("test overlap done");
    endtask

    // Reset in mid-frame cuts the line and drops any stale request
    task automatic t_reset_mid;
        u_master.send(~pat_a, 240);
        repeat (600) @(negedge core_clk);
        chk(32'(tx_busy), 32'h1);
        resetn = 1'b0;
        @(negedge core_clk);
        chk(32'({led_serial_out, tx_busy}), 32'h0);
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        repeat (20) @(negedge core_clk);
        chk(32'({led_serial_out, tx_busy}), 32'h0);
        u_master.send(pat_a, 240);
        decode(pat_a);
        $display("test mid reset done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (6) @(negedge core_clk);
        t_reset;
        resetn = 1'b1;
        @(negedge core_clk);
        t_full;
        t_partial;
        t_overlap;
        t_reset_mid;
        tally_and_finish;
    end

    // Five frames of about 14000 cycles each, with margin
    initial
    begin
        #2200000;
        err_count++;
        tally_and_finish;
    end
endmodule

// ==== dv/slc_spi_master.sv ====
`timescale 1ns/10ps

module slc_spi_master
(
    output logic              spi_sclk,
    output slc_pkg::slc_spi_t spi_in
);
    import slc_pkg::*;

    initial
    begin
        spi_sclk = 1'b0;
        spi_in = '{cs_n: 1'b1, mosi: 1'b0};
    end

    // Serial clock at 6 ns runs only inside a transfer
    task automatic send(input logic [239:0] f, input int n);
        spi_in.cs_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--)
        begin
            spi_in.mosi = f[i];
            #3 spi_sclk = 1'b1;
            #3 spi_sclk = 1'b0;
        end
        #150;
        spi_in.mosi = ~spi_in.mosi;
        spi_in.cs_n = 1'b1;
    endtask
endmodule
